// File: rtl/tpa_output_stage.sv
// Time-proportional drive and analog output scaling for a two-loop controller.
// Functional notes
// - Four cycle periods, 1..1000 s, default 30
// - Output on for percentage of period
// - Analog type codes select four current ranges
// - Analog carries control output or retransmission
// - Zero and full points, -5..105 percent
// - Each analog output selects its own type
// - Drive code 2 gives loop-one current output
// - Retransmit code 3 sends temperature control output
// - Codes 0/1/3: relay, pulse, on/off relay
`timescale 1ns/10ps
module tpa_output_stage #(
  parameter int SEC_CYCLES = tpa_pkg::SEC_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [9:0]  tempHeatCyclePeriod,
  input  wire logic [9:0]  humidHeatCyclePeriod,
  input  wire logic [9:0]  tempCoolCyclePeriod,
  input  wire logic [9:0]  humidCoolCyclePeriod,
  input  wire logic [11:0] tempHeatPct,
  input  wire logic [11:0] humidHeatPct,
  input  wire logic [11:0] tempCoolPct,
  input  wire logic [11:0] humidCoolPct,
  input  wire logic [3:0]  loopOneDriveType,
  input  wire logic [3:0]  tempRetransmitSelect,
  input  wire logic [11:0] retransmitFirst,
  input  wire logic [11:0] retransmitSecond,
  input  wire logic [11:0] retransmitThird,
  input  wire logic [1:0]  aoutFirstSignalType,
  input  wire logic [1:0]  aoutSecondSignalType,
  input  wire logic [1:0]  aoutThirdSignalType,
  input  wire logic [11:0] aoutFirstFullPoint,
  input  wire logic [11:0] aoutFirstZeroPoint,
  input  wire logic [11:0] aoutSecondFullPoint,
  input  wire logic [11:0] aoutSecondZeroPoint,
  input  wire logic [11:0] aoutThirdFullPoint,
  input  wire logic [11:0] aoutThirdZeroPoint,
  output logic      [3:0]  tpOut,
  output logic             relayDrive,
  output logic             pulseDrive,
  output logic      [14:0] aoutFirstUa,
  output logic      [14:0] aoutSecondUa,
  output logic      [14:0] aoutThirdUa
);

  // ************************************************************
  // Input gathering.
  // ************************************************************
  tpa_pkg::tpa_state_type s_q;
  tpa_pkg::tpa_state_type s_d;
  logic [3:0][9:0]  perIn;
  logic [3:0][11:0] pctIn;
  logic [2:0][11:0] srcIn;
  logic [2:0][11:0] fullIn;
  logic [2:0][11:0] zeroIn;
  logic [2:0][1:0]  typeIn;

  // Channel order: temp heat, humid heat, temp cool, humid cool.
  assign perIn  = {humidCoolCyclePeriod, tempCoolCyclePeriod,
                   humidHeatCyclePeriod, tempHeatCyclePeriod};
  assign pctIn  = {humidCoolPct, tempCoolPct, humidHeatPct, tempHeatPct};
  assign fullIn = {aoutThirdFullPoint, aoutSecondFullPoint, aoutFirstFullPoint};
  assign zeroIn = {aoutThirdZeroPoint, aoutSecondZeroPoint, aoutFirstZeroPoint};
  assign typeIn = {aoutThirdSignalType, aoutSecondSignalType, aoutFirstSignalType};

  // First output carries the loop-one control output in current mode, the third
  // one the temperature control output when retransmission of it is selected.
  assign srcIn[0] = (loopOneDriveType == tpa_pkg::DRV_CURRENT) ? tempHeatPct
                                                               : retransmitFirst;
  assign srcIn[1] = retransmitSecond;
  assign srcIn[2] = (tempRetransmitSelect == tpa_pkg::RET_CTRL_OUT) ? tempHeatPct
                                                                    : retransmitThird;

  // ************************************************************
  // Next-state logic.
  // ************************************************************
  // The on-time compare uses whole seconds, so a fraction of a second rounds up.
  always_comb begin
    int num;
    int span;
    int pm;
    int lo;
    int hi;
    int ua;
    logic [9:0]  per;
    logic [11:0] pct;
    num  = 0;
    span = 0;
    pm   = 0;
    lo   = 0;
    hi   = 0;
    ua   = 0;
    per  = '0;
    pct  = '0;
    s_d  = s_q;
    s_d.secPulse = 1'b0;
    if (int'(s_q.tick) >= SEC_CYCLES - 1) begin
      s_d.tick     = '0;
      s_d.secPulse = 1'b1;
    end else begin
      s_d.tick = s_q.tick + 28'h0000001;
    end
    for (int i = 0; i < tpa_pkg::NUM_TP; i++) begin
      // Period and percentage are clamped, then latched at each cycle start so a
      // change mid-cycle cannot produce a runt pulse.
      per = perIn[i];
      if (per < tpa_pkg::PER_MIN) per = tpa_pkg::PER_MIN;
      if (per > tpa_pkg::PER_MAX) per = tpa_pkg::PER_MAX;
      pct = pctIn[i];
      if (pct[11]) pct = tpa_pkg::PCT_ZERO;
      if (!pct[11] && pct > tpa_pkg::PCT_FULL) pct = tpa_pkg::PCT_FULL;
      if (s_q.secPulse) begin
        if (s_q.secCnt[i] + 10'h001 >= s_q.perLat[i]) begin
          s_d.secCnt[i] = '0;
          s_d.perLat[i] = per;
          s_d.pctLat[i] = pct;
        end else begin
          s_d.secCnt[i] = s_q.secCnt[i] + 10'h001;
        end
      end
      s_d.tpOn[i] = (int'(s_q.secCnt[i]) * tpa_pkg::PERMILLE)
                  < (int'(s_q.perLat[i]) * int'(s_q.pctLat[i]));
    end
    // Loop-one drive steering.
    unique case (loopOneDriveType)
      tpa_pkg::DRV_TP_RELAY: begin
        s_d.relay = s_q.tpOn[0];
        s_d.pulse = 1'b0;
      end
      tpa_pkg::DRV_TP_PULSE: begin
        s_d.relay = 1'b0;
        s_d.pulse = s_q.tpOn[0];
      end
      tpa_pkg::DRV_ONOFF: begin
        s_d.relay = !tempHeatPct[11] && (tempHeatPct >= tpa_pkg::PCT_ONOFF);
        s_d.pulse = 1'b0;
      end
      default: begin
        s_d.relay = 1'b0;
        s_d.pulse = 1'b0;
      end
    endcase
    // Analog scaling; a zero span acts as a step at the zero point.
    for (int k = 0; k < tpa_pkg::NUM_AO; k++) begin
      num  = int'($signed(srcIn[k])) - int'($signed(zeroIn[k]));
      span = int'($signed(fullIn[k])) - int'($signed(zeroIn[k]));
      if (span == 0) pm = (num >= 0) ? tpa_pkg::PERMILLE : 0;
      else pm = (num * tpa_pkg::PERMILLE) / span;
      if (pm < 0) pm = 0;
      if (pm > tpa_pkg::PERMILLE) pm = tpa_pkg::PERMILLE;
      unique case (typeIn[k])
        tpa_pkg::AO_4_20: begin
          lo = int'(tpa_pkg::UA_FOUR);
          hi = int'(tpa_pkg::UA_TOP);
        end
        tpa_pkg::AO_0_20: begin
          lo = int'(tpa_pkg::UA_ZERO);
          hi = int'(tpa_pkg::UA_TOP);
        end
        tpa_pkg::AO_20_4: begin
          lo = int'(tpa_pkg::UA_TOP);
          hi = int'(tpa_pkg::UA_FOUR);
        end
        tpa_pkg::AO_20_0: begin
          lo = int'(tpa_pkg::UA_TOP);
          hi = int'(tpa_pkg::UA_ZERO);
        end
      endcase
      ua = lo + ((hi - lo) * pm) / tpa_pkg::PERMILLE;
      s_d.aoutUa[k] = ua[14:0];
    end
  end

  // ************************************************************
  // State register.
  // ************************************************************
  // Reset periods start at 30 s, latched percentages at 0 and analog outputs at 0 uA.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q          <= '0;
      s_q.perLat   <= {tpa_pkg::NUM_TP{tpa_pkg::PER_RESET}};
      s_q.aoutUa   <= {tpa_pkg::UA_ZERO, tpa_pkg::UA_ZERO, tpa_pkg::UA_ZERO};
    end else begin
      s_q <= s_d;
    end
  end

  assign tpOut        = s_q.tpOn;
  assign relayDrive   = s_q.relay;
  assign pulseDrive   = s_q.pulse;
  assign aoutFirstUa  = s_q.aoutUa[0];
  assign aoutSecondUa = s_q.aoutUa[1];
  assign aoutThirdUa  = s_q.aoutUa[2];

  // ************************************************************
  // Assertions.
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_period_bound: assert property (s_q.secCnt[0] < s_q.perLat[0])
    else $error("Seconds count reached the latched period.");
  a_period_range: assert property (s_q.perLat[1] >= tpa_pkg::PER_MIN
                                   && s_q.perLat[1] <= tpa_pkg::PER_MAX)
    else $error("Latched period out of range.");
  a_tp_zero: assert property (s_q.pctLat[2] == tpa_pkg::PCT_ZERO |=> !s_q.tpOn[2])
    else $error("Output on at zero percent.");
  a_tp_full: assert property (s_q.pctLat[1] == tpa_pkg::PCT_FULL
                              && $stable(s_q.pctLat[1]) |=> s_q.tpOn[1])
    else $error("Output off at full percent.");
  a_relay_follow: assert property (loopOneDriveType == tpa_pkg::DRV_TP_RELAY
                                   |=> relayDrive == $past(s_q.tpOn[0]) && !pulseDrive)
    else $error("Relay does not follow the proportional drive.");
  a_current_quiet: assert property (loopOneDriveType == tpa_pkg::DRV_CURRENT
                                    |=> !relayDrive && !pulseDrive)
    else $error("Discrete drive active in current mode.");
  a_range_low: assert property (aoutFirstSignalType == tpa_pkg::AO_4_20
                                |=> aoutFirstUa >= tpa_pkg::UA_FOUR
                                    && aoutFirstUa <= tpa_pkg::UA_TOP)
    else $error("First analog output outside 4 to 20 mA.");
  a_zero_point: assert property (tempRetransmitSelect == tpa_pkg::RET_CTRL_OUT
                                 && aoutThirdSignalType == tpa_pkg::AO_0_20
                                 && aoutThirdZeroPoint == tempHeatPct
                                 && aoutThirdFullPoint != aoutThirdZeroPoint
                                 |=> aoutThirdUa == tpa_pkg::UA_ZERO)
    else $error("Third output not at minimum at its zero point.");
  a_second_tick: assert property (int'(s_q.tick) == SEC_CYCLES - 1 |=> s_q.secPulse)
    else $error("Second pulse missing.");

  c_tp_rise: cover property (!s_q.tpOn[0] ##1 s_q.tpOn[0]);
  c_cycle_wrap: cover property (s_q.secPulse && s_q.secCnt[0] == 10'h000);
  c_inverted: cover property ($signed(aoutThirdFullPoint) < $signed(aoutThirdZeroPoint)
                              ##1 aoutThirdUa == tpa_pkg::UA_TOP);

endmodule

// File: pkg/tpa_pkg.sv
// Constants and state type of the time-proportional output and analog scaling block.
package tpa_pkg;

  // ************************************************************
  // Timebase.
  // ************************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int SECOND_NS     = 1_000_000_000;
  localparam int SEC_CYCLES    = SECOND_NS / CLK_PERIOD_NS;
  localparam int TICK_W        = 28;

  // ************************************************************
  // Cycle periods, seconds.
  // ************************************************************
  localparam int          NUM_TP     = 4;
  localparam int          PER_W      = 10;
  localparam logic [9:0]  PER_MIN    = 10'h001;
  localparam logic [9:0]  PER_MAX    = 10'h3e8;
  localparam logic [9:0]  PER_RESET  = 10'h01e;

  // ************************************************************
  // Percentages in tenths of a percent, signed.
  // ************************************************************
  localparam int           PCT_W      = 12;
  localparam logic [11:0]  PCT_FULL   = 12'h3e8;
  localparam logic [11:0]  PCT_ZERO   = 12'h000;
  localparam logic [11:0]  PCT_ONOFF  = 12'h1f4;
  localparam logic [11:0]  PT_FULL_RESET = 12'h3e8;
  localparam logic [11:0]  PT_ZERO_RESET = 12'h000;
  localparam int           PERMILLE   = 1000;

  // ************************************************************
  // Selector codes.
  // ************************************************************
  localparam logic [3:0] DRV_TP_RELAY = 4'h0;
  localparam logic [3:0] DRV_TP_PULSE = 4'h1;
  localparam logic [3:0] DRV_CURRENT  = 4'h2;
  localparam logic [3:0] DRV_ONOFF    = 4'h3;
  localparam logic [3:0] RET_CTRL_OUT = 4'h3;
  localparam logic [1:0] AO_4_20      = 2'h0;
  localparam logic [1:0] AO_0_20      = 2'h1;
  localparam logic [1:0] AO_20_4      = 2'h2;
  localparam logic [1:0] AO_20_0      = 2'h3;

  // ************************************************************
  // Analog levels in microamperes.
  // ************************************************************
  localparam int          UA_W    = 15;
  localparam logic [14:0] UA_ZERO = 15'h0000;
  localparam logic [14:0] UA_FOUR = 15'h0fa0;
  localparam logic [14:0] UA_TOP  = 15'h4e20;
  localparam int          NUM_AO  = 3;

  typedef struct packed {
    logic [TICK_W-1:0]            tick;
    logic                         secPulse;
    logic [NUM_TP-1:0][PER_W-1:0] secCnt;
    logic [NUM_TP-1:0][PER_W-1:0] perLat;
    logic [NUM_TP-1:0][PCT_W-1:0] pctLat;
    logic [NUM_TP-1:0]            tpOn;
    logic                         relay;
    logic                         pulse;
    logic [NUM_AO-1:0][UA_W-1:0]  aoutUa;
  } tpa_state_type;

endpackage

// File: bench/tpa_actuator_model.sv
// Actuator model that totals the cycles each drive line is energised.
`timescale 1ns/10ps
module tpa_actuator_model (
  input  wire logic             clk,
  input  wire logic             clear,
  input  wire logic [5:0]       drives,
  output logic      [5:0][15:0] onCount
);
  // ************************************************************
  // On-time integration.
  // ************************************************************
  // A relay or heater only responds to the level, so on-time per line is what matters.
  always_ff @(posedge clk) begin
    for (int i = 0; i < 6; i++) begin
      if (clear) begin
        onCount[i] <= 16'h0000;
      end else begin
        onCount[i] <= onCount[i] + 16'(drives[i]);
      end
    end
  end
endmodule

// File: bench/time_prop_output_and_analog_scaling_test.sv
// Self-checking bench for the time-proportional drive and analog scaling block.
`timescale 1ns/10ps
module time_prop_output_and_analog_scaling_test;
  // ************************************************************
  // Signals.
  // ************************************************************
  logic             clk;
  logic             resetn;
  logic             clear;
  logic [9:0]       per [4];
  logic [11:0]      pct [4];
  logic [3:0]       drvType;
  logic [3:0]       retSel;
  logic [11:0]      ret [3];
  logic [1:0]       aType [3];
  logic [11:0]      fullPt [3];
  logic [11:0]      zeroPt [3];
  logic [3:0]       tpOut;
  logic             relayDrive;
  logic             pulseDrive;
  logic [14:0]      ua [3];
  logic [5:0][15:0] onCount;
  int               n_fail;
  int               n_compared;
  int               drvTab [5] = '{0, 1, 2, 3, 5};
  int               relTab [5] = '{120, 0, 0, 200, 0};
  int               pulTab [5] = '{0, 120, 0, 0, 0};

  // A short second of 10 clocks keeps each set cycle period at 100 clocks or fewer.
  tpa_output_stage #(.SEC_CYCLES(10)) dut_u (
    .clk(clk), .resetn(resetn),
    .tempHeatCyclePeriod(per[0]), .humidHeatCyclePeriod(per[1]),
    .tempCoolCyclePeriod(per[2]), .humidCoolCyclePeriod(per[3]),
    .tempHeatPct(pct[0]), .humidHeatPct(pct[1]), .tempCoolPct(pct[2]), .humidCoolPct(pct[3]),
    .loopOneDriveType(drvType), .tempRetransmitSelect(retSel),
    .retransmitFirst(ret[0]), .retransmitSecond(ret[1]), .retransmitThird(ret[2]),
    .aoutFirstSignalType(aType[0]), .aoutSecondSignalType(aType[1]),
    .aoutThirdSignalType(aType[2]),
    .aoutFirstFullPoint(fullPt[0]), .aoutFirstZeroPoint(zeroPt[0]),
    .aoutSecondFullPoint(fullPt[1]), .aoutSecondZeroPoint(zeroPt[1]),
    .aoutThirdFullPoint(fullPt[2]), .aoutThirdZeroPoint(zeroPt[2]),
    .tpOut(tpOut), .relayDrive(relayDrive), .pulseDrive(pulseDrive),
    .aoutFirstUa(ua[0]), .aoutSecondUa(ua[1]), .aoutThirdUa(ua[2]));

  tpa_actuator_model act_u (
    .clk(clk), .clear(clear), .drives({pulseDrive, relayDrive, tpOut}), .onCount(onCount));

  // ************************************************************
  // Helpers.
  // ************************************************************
  // Expected current in microamps, worked out from the range code and the two points.
  function automatic int uaExp(input int t, input int s, input int z, input int f);
    int pm;
    int lo;
    int hi;
    if (f == z) pm = (s >= z) ? 1000 : 0;
    else pm = (s - z) * 1000 / (f - z);
    pm = (pm < 0) ? 0 : (pm > 1000) ? 1000 : pm;
    lo = (t == 0) ? 4000 : (t == 1) ? 0 : 20000;
    hi = (t < 2) ? 20000 : (t == 2) ? 4000 : 0;
    return lo + (hi - lo) * pm / 1000;
  endfunction

  task automatic check(input logic [15:0] got, input int exp, input string what);
    n_compared++;
    if (got !== 16'(exp)) begin
      n_fail++;
      $display("FAIL %0t %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask

  // Expected figure for analog output i from source s, using its current settings.
  task automatic aoCheck(input int i, input int s);
    check(16'(ua[i]), uaExp(aType[i], s, $signed(zeroPt[i]), $signed(fullPt[i])), "analog");
  endtask

  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Watchdog so a stalled run still reaches the verdict.
  initial begin
    #100000;
    n_fail++;
    results();
  end

  // ************************************************************
  // Test sequence.
  // ************************************************************
  initial begin
    resetn = 1'b0; clear = 1'b0; drvType = 4'h0; retSel = 4'h0;
    per = '{10'h00a, 10'h001, 10'h005, 10'h000};
    pct = '{12'h000, 12'h3e8, 12'h1f4, -12'sd100};
    ret = '{12'h0fa, 12'h3fc, -12'sd50};
    aType = '{2'h0, 2'h0, 2'h0};
    fullPt = '{12'h3e8, 12'h3e8, 12'h3e8};
    zeroPt = '{12'h000, 12'h000, 12'h000};
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    // Range codes per output, opposite codes on the first two at the same time.
    for (int t = 0; t < 4; t++) begin
      aType[0] = 2'(t);
      aType[1] = 2'(3 - t);
      @(negedge clk);
      aoCheck(0, 250);
      aoCheck(1, 1020);
    end
    aoCheck(2, -50);
    check(16'(tpOut), 0, "first period off");
    $display("test analog ranges done");
    // Split V-mode: loop one on current output, temperature retransmitted on output three.
    // Output three runs 0 to 20 mA so that its zero point lands on the range floor.
    aType = '{2'h0, 2'h0, 2'h1};
    drvType = 4'h2; retSel = 4'h3;
    zeroPt = '{12'h0fa, -12'sd50, 12'h2ee};
    fullPt = '{12'h3e8, 12'h41a, 12'h000};
    ret[1] = 12'h1f4;
    for (int k = 0; k < 4; k++) begin
      pct[0] = (k == 0) ? 12'h1f4 : (k == 1) ? 12'h064 : (k == 2) ? 12'h41a : 12'h2ee;
      @(negedge clk);
      aoCheck(0, $signed(pct[0]));
      aoCheck(2, $signed(pct[0]));
      aoCheck(1, 500);
    end
    $display("test split outputs done");
    // Drive duty over a 20 s window, a multiple of every period in use.
    pct[0] = 12'h258;
    repeat (400) @(negedge clk);
    for (int k = 0; k < 5; k++) begin
      drvType = 4'(drvTab[k]);
      repeat (3) @(negedge clk);
      clear = 1'b1;
      @(negedge clk);
      clear = 1'b0;
      repeat (200) @(negedge clk);
      check(onCount[4], relTab[k], "relay on-time");
      check(onCount[5], pulTab[k], "pulse on-time");
      if (k == 0) begin
        check(onCount[0], 120, "temp heat on-time");
        check(onCount[1], 200, "humid heat on-time");
        check(onCount[2], 120, "temp cool on-time");
        check(onCount[3], 0, "humid cool on-time");
      end
    end
    $display("test drive duty done");
    results();
  end
endmodule
